// file: rtl/pdc_pkg.sv
package pdc_pkg;

  // byte offsets of the registers in configuration space
  localparam logic [7:0] PDC_OFF_CAP_ID = 8'h90;
  localparam logic [7:0] PDC_OFF_NEXT_PTR = 8'h91;
  localparam logic [7:0] PDC_OFF_PROTO_CAPS = 8'h92;
  localparam logic [7:0] PDC_OFF_FEAT_CAPS = 8'h94;
  localparam logic [7:0] PDC_OFF_FEAT_CTL = 8'h98;

  // fixed byte values at the head of the capability structure
  localparam logic [7:0] PDC_CAP_ID_VAL = 8'h10;
  localparam logic [7:0] PDC_NEXT_PTR_VAL = 8'h00;

  // protocol capabilities word: fields and reset value
  localparam logic [15:0] PDC_PROTO_CAPS_RST = 16'h0061;
  localparam logic [3:0] PDC_VERSION_VAL = 4'h1;
  localparam logic [3:0] PDC_PORT_KIND_VAL = 4'h6;
  localparam logic [4:0] PDC_INT_NUM_VAL = 5'h00;
  localparam logic [1:0] PDC_PROTO_RSVD_VAL = 2'h0;
  localparam int PDC_VERSION_LSB = 0;
  localparam int PDC_KIND_LSB = 4;
  localparam int PDC_SLOT_BIT = 8;
  localparam int PDC_INT_NUM_LSB = 9;
  localparam int PDC_PROTO_RSVD_LSB = 14;

  // port feature capabilities word, every field fixed
  localparam logic [31:0] PDC_FEAT_CAPS_VAL = 32'h0000_8001;
  localparam int PDC_PAYLOAD_SUP_LSB = 0;
  localparam logic [2:0] PDC_PAYLOAD_SUP_VAL = 3'h1;
  localparam int PDC_BORROW_LSB = 3;
  localparam int PDC_WIDE_TAG_BIT = 5;
  localparam int PDC_ATTN_BUTTON_BIT = 12;
  localparam int PDC_ATTN_LAMP_BIT = 13;
  localparam int PDC_POWER_LAMP_BIT = 14;
  localparam int PDC_ROLE_ERR_BIT = 15;
  localparam int PDC_POWER_VALUE_LSB = 18;
  localparam int PDC_POWER_SCALE_LSB = 26;
  localparam logic [31:0] PDC_FEAT_RSVD_MASK = 32'hf003_0fc0;

  // port feature control register
  localparam logic [15:0] PDC_FEAT_CTL_RST = 16'h2000;
  localparam logic [15:0] PDC_FEAT_CTL_WMASK = 16'h70e0;
  localparam int PDC_READ_LIMIT_LSB = 12;
  localparam int PDC_PAYLOAD_LIMIT_LSB = 5;
  localparam logic [2:0] PDC_READ_LIMIT_RST = 3'h2;
  localparam logic [15:0] PDC_STATUS_VAL = 16'h0000;

  // access sequencer states
  typedef enum logic [1:0] {
    PDC_ST_IDLE = 2'b01,
    PDC_ST_ACK = 2'b10
  } pdc_state_t;

  // state of the access sequencer
  typedef struct packed {
    pdc_state_t state;
    logic [31:0] rdata;
    logic ctl_written;
  } pdc_core_t;

  // dword index of a byte offset
  function automatic logic [5:0] pdc_dw(input logic [7:0] addr);
    return addr[7:2];
  endfunction

  // merge write data into a 16-bit register by byte lane and writable mask
  function automatic logic [15:0] pdc_merge16(input logic [15:0] old_val,
                                              input logic [15:0] wdata,
                                              input logic [1:0] be,
                                              input logic [15:0] wmask);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_val & ~lane) | (wdata & lane);
  endfunction

endpackage

// file: rtl/pdc_feat_ctl.sv
`timescale 1ns/100ps
// holder of the port feature control register
module pdc_feat_ctl
  import pdc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_wr_en,
  input wire logic [15:0] i_wdata,
  input wire logic [1:0] i_be,
  output logic [15:0] o_value
);

  // register state
  typedef struct packed {
    logic [15:0] ctl;
  } pdc_ctl_state_t;

  pdc_ctl_state_t st_reg; // registered state
  pdc_ctl_state_t st_next; // next state

  // only the writable fields move; fixed bits keep their reset value
  always_comb begin
    st_next = st_reg;
    if (i_wr_en) begin
      st_next.ctl = pdc_merge16(st_reg.ctl, i_wdata, i_be, PDC_FEAT_CTL_WMASK); // R17
    end
  end

  // reset to the documented pattern with the read limit at its default
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg.ctl <= PDC_FEAT_CTL_RST; // R15 R16
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_value = st_reg.ctl;

endmodule // pdc_feat_ctl

// file: rtl/pdc_downstream_caps.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1: next pointer byte reads zero, list ends
// R2: protocol capabilities word, reset value 0061h
// R3: interrupt message number field always zero
// R4: slot bit follows general control, read-only
// R5: port kind code reads switch downstream
// R6: capability version field reads one
// R7: feature capabilities word fixed at 8001h
// R8: captured power scale and value read zero
// R9: role-based error support bit reads one
// R10: lamp and button present bits zero
// R11: wide tag support bit reads zero
// R12: borrowed function support field reads zero
// R13: payload limit supported encodes 256 bytes
// R14: reserved bits of capability words read zero
// R15: feature control resets to 2000h
// R16: read request limit resets to 512 bytes
// R17: writes to fixed bits change nothing
module pdc_downstream_caps
  import pdc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [7:0] i_cfg_addr,
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic i_slot_implemented,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_ack,
  output logic [2:0] o_read_request_limit,
  output logic [2:0] o_payload_limit
);

  pdc_core_t st_reg; // registered sequencer state
  pdc_core_t st_next; // next sequencer state

  logic req_take; // a request is taken this cycle
  logic [5:0] req_dw; // dword index of the request
  logic hit_head; // dword holding id, next pointer and protocol word
  logic hit_feat; // feature capabilities dword
  logic hit_ctl; // feature control dword
  logic ctl_wr_en; // write strobe toward the control register
  logic [15:0] ctl_value; // current control register contents
  logic [15:0] proto_caps; // assembled protocol capabilities word
  logic [31:0] feat_caps; // assembled feature capabilities word
  logic [31:0] read_word; // read data for the addressed dword

  // address decode; the low two offset bits are ignored, byte lanes come from the byte enables
  assign req_dw = pdc_dw(i_cfg_addr);
  assign hit_head = (req_dw == pdc_dw(PDC_OFF_CAP_ID));
  assign hit_feat = (req_dw == pdc_dw(PDC_OFF_FEAT_CAPS));
  assign hit_ctl = (req_dw == pdc_dw(PDC_OFF_FEAT_CTL));

  // a new request is only taken while no answer is pending
  assign req_take = (i_cfg_rd || i_cfg_wr) && (st_reg.state == PDC_ST_IDLE);

  // only the control dword accepts writes; all other words are fixed
  assign ctl_wr_en = req_take && i_cfg_wr && hit_ctl; // R17

  // protocol capabilities word, built from its fixed fields and the slot level
  always_comb begin
    proto_caps = '0;
    proto_caps[PDC_VERSION_LSB +: 4] = PDC_VERSION_VAL; // R6
    proto_caps[PDC_KIND_LSB +: 4] = PDC_PORT_KIND_VAL; // R5
    // the slot level is owned by the general control register elsewhere
    proto_caps[PDC_SLOT_BIT] = i_slot_implemented; // R4
    proto_caps[PDC_INT_NUM_LSB +: 5] = PDC_INT_NUM_VAL; // R3
    proto_caps[PDC_PROTO_RSVD_LSB +: 2] = PDC_PROTO_RSVD_VAL; // R14
  end

  // feature capabilities word, assembled field by field; nothing in it moves
  always_comb begin
    feat_caps = '0;
    // largest packet payload the port handles
    feat_caps[PDC_PAYLOAD_SUP_LSB +: 3] = PDC_PAYLOAD_SUP_VAL; // R13
    // function numbers are never borrowed to widen tags
    feat_caps[PDC_BORROW_LSB +: 2] = '0; // R12
    // short tags only, so the tag tracker stays small
    feat_caps[PDC_WIDE_TAG_BIT] = 1'b0; // R11
    // no lamps and no button hang off this port
    feat_caps[PDC_ATTN_BUTTON_BIT] = 1'b0; // R10
    feat_caps[PDC_ATTN_LAMP_BIT] = 1'b0; // R10
    feat_caps[PDC_POWER_LAMP_BIT] = 1'b0; // R10
    // role-based error reporting is supported
    feat_caps[PDC_ROLE_ERR_BIT] = 1'b1; // R9
    // captured power fields only mean something on an upstream port
    feat_caps[PDC_POWER_VALUE_LSB +: 8] = '0; // R8
    feat_caps[PDC_POWER_SCALE_LSB +: 2] = '0; // R8
    // reserved ranges are cleared last, so a field slip cannot leak into them
    feat_caps = feat_caps & ~PDC_FEAT_RSVD_MASK; // R14
  end

  // read multiplexer; dwords outside this block read as zero
  always_comb begin
    read_word = '0;
    if (hit_head) begin
      // id byte, then the end-of-list pointer, then the protocol word
      read_word = {proto_caps, PDC_NEXT_PTR_VAL, PDC_CAP_ID_VAL}; // R1 R2
    end else if (hit_feat) begin
      // every field fixed, reserved and upstream-only fields are zero
      read_word = feat_caps; // R7
    end else if (hit_ctl) begin
      // the status half is not kept here and reads zero
      read_word = {PDC_STATUS_VAL, ctl_value};
    end
  end

  // sequencer next state: take, answer one cycle later, then idle again
  always_comb begin
    st_next = st_reg;
    unique case (st_reg.state)
      PDC_ST_IDLE: begin
        if (req_take) begin
          st_next.state = PDC_ST_ACK;
          // a read returns the word as it stood before a same-cycle write
          if (i_cfg_rd) begin
            st_next.rdata = read_word;
          end
          if (ctl_wr_en) begin
            st_next.ctl_written = 1'b1;
          end
        end
      end
      PDC_ST_ACK: begin
        // requests in this cycle are ignored; the host waits for ack
        st_next.state = PDC_ST_IDLE;
      end
      default: begin
        // a damaged one-hot code falls back to idle
        st_next.state = PDC_ST_IDLE;
      end
    endcase
  end

  // state register; read data holds until the next read replaces it
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg.state <= PDC_ST_IDLE;
      st_reg.rdata <= '0;
      st_reg.ctl_written <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // control register with byte-lane writes of its writable fields
  pdc_feat_ctl u_feat_ctl (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_wr_en(ctl_wr_en),
    .i_wdata(i_cfg_wdata[15:0]),
    .i_be(i_cfg_be[1:0]),
    .o_value(ctl_value)
  );

  // outputs; the limits steer the port's request and payload sizing
  assign o_cfg_rdata = st_reg.rdata;
  assign o_cfg_ack = (st_reg.state == PDC_ST_ACK);
  assign o_read_request_limit = ctl_value[PDC_READ_LIMIT_LSB +: 3]; // R16
  assign o_payload_limit = ctl_value[PDC_PAYLOAD_LIMIT_LSB +: 3];

  // checks on the answers and the register contents
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  // a taken read of a given dword
  sequence s_read_head;
    i_cfg_rd && (st_reg.state == PDC_ST_IDLE) && hit_head;
  endsequence

  sequence s_read_feat;
    i_cfg_rd && (st_reg.state == PDC_ST_IDLE) && hit_feat;
  endsequence

  // a taken read of the control dword
  sequence s_read_ctl;
    i_cfg_rd && (st_reg.state == PDC_ST_IDLE) && hit_ctl;
  endsequence

  // a taken read of a dword that this block does not map
  sequence s_read_other;
    i_cfg_rd && (st_reg.state == PDC_ST_IDLE) && !hit_head && !hit_feat && !hit_ctl;
  endsequence

  // the answer that follows a taken request
  sequence s_answer;
    o_cfg_ack ##1 !o_cfg_ack;
  endsequence

  a_answer_timing: assert property (
    req_take |=> s_answer)
    else $error("answer not a single cycle after the request");

  a_next_ptr_zero: assert property ( // R1
    s_read_head |=> o_cfg_ack && (o_cfg_rdata[15:8] == 8'h00))
    else $error("next pointer byte not zero");

  a_proto_word_reset: assert property ( // R2
    (s_read_head and (!i_slot_implemented)) |=>
      (o_cfg_rdata[31:16] == PDC_PROTO_CAPS_RST))
    else $error("protocol capabilities word wrong");

  // a host that waits out each answer before its next access lands that
  // access three cycles after the write it follows
  a_int_num_fixed: assert property ( // R3
    (i_cfg_wr && hit_head && (st_reg.state == PDC_ST_IDLE)) ##3 s_read_head |=>
      (o_cfg_rdata[29:25] == 5'h00))
    else $error("interrupt message number not zero after write");

  a_slot_follows_level: assert property ( // R4
    s_read_head |=> (o_cfg_rdata[24] == $past(i_slot_implemented)))
    else $error("slot bit does not follow the general control level");

  a_port_kind_fixed: assert property ( // R5
    s_read_head |=> (o_cfg_rdata[23:20] == 4'h6))
    else $error("port kind code wrong");

  a_version_fixed: assert property ( // R6
    s_read_head |=> (o_cfg_rdata[19:16] == 4'h1))
    else $error("capability version wrong");

  a_feat_word_value: assert property ( // R7
    s_read_feat |=> o_cfg_ack && (o_cfg_rdata == 32'h0000_8001) ##1 !o_cfg_ack)
    else $error("feature capabilities word wrong");

  a_power_fields_zero: assert property ( // R8
    s_read_feat |=> (o_cfg_rdata[27:18] == 10'h000))
    else $error("captured power fields not zero");

  a_role_error_set: assert property ( // R9
    s_read_feat |=> o_cfg_rdata[PDC_ROLE_ERR_BIT])
    else $error("role based error bit not set");

  a_lamps_absent: assert property ( // R10
    s_read_feat |=> (o_cfg_rdata[14:12] == 3'h0))
    else $error("lamp or button bit set");

  a_wide_tag_off: assert property ( // R11
    s_read_feat |=> !o_cfg_rdata[PDC_WIDE_TAG_BIT])
    else $error("wide tag bit set");

  a_borrow_none: assert property ( // R12
    s_read_feat |=> (o_cfg_rdata[4:3] == 2'h0))
    else $error("borrowed function field not zero");

  a_payload_256: assert property ( // R13
    s_read_feat |=> (o_cfg_rdata[2:0] == 3'h1))
    else $error("payload limit supported wrong");

  a_reserved_zero: assert property ( // R14
    (s_read_feat |=> ((o_cfg_rdata & 32'hf003_0fc0) == 32'h0)) and
    (s_read_head |=> (o_cfg_rdata[31:30] == 2'h0)))
    else $error("reserved bits not zero");

  a_ctl_reset_value: assert property ( // R15
    !st_reg.ctl_written |-> (ctl_value == 16'h2000))
    else $error("control register left its reset value unwritten");

  a_read_limit_default: assert property ( // R16
    !st_reg.ctl_written |-> (o_read_request_limit == 3'h2))
    else $error("read request limit not 512 bytes before a write");

  a_fixed_bits_hold: assert property ( // R17
    ctl_wr_en |=> ((ctl_value & ~PDC_FEAT_CTL_WMASK) == 16'h0000) &&
      (!$past(i_cfg_be[1]) || (ctl_value[14:12] == $past(i_cfg_wdata[14:12]))) &&
      (!$past(i_cfg_be[0]) || (ctl_value[7:5] == $past(i_cfg_wdata[7:5]))))
    else $error("control write did not respect the writable fields");

  a_caps_write_ignored: assert property ( // R17
    (i_cfg_wr && hit_feat && (st_reg.state == PDC_ST_IDLE)) ##3 s_read_feat |=>
      (o_cfg_rdata == PDC_FEAT_CAPS_VAL))
    else $error("write changed the feature capabilities word");

  a_head_write_ignored: assert property ( // R17
    (i_cfg_wr && hit_head && (st_reg.state == PDC_ST_IDLE)) ##3 s_read_head |=>
      (o_cfg_rdata[23:0] == 24'h61_0010))
    else $error("write changed the head dword");

  a_ctl_read_value: assert property ( // R15
    s_read_ctl |=>
      (o_cfg_rdata == {PDC_STATUS_VAL, $past(ctl_value)}))
    else $error("control dword read wrong");

  a_status_half_zero: assert property ( // R15
    s_read_ctl |=>
      (o_cfg_rdata[31:16] == 16'h0000))
    else $error("status half of the control dword not zero");

  a_other_reads_zero: assert property (
    s_read_other |=>
      (o_cfg_rdata == 32'h0000_0000))
    else $error("unmapped dword did not read zero");

  a_id_byte: assert property (
    s_read_head |=>
      (o_cfg_rdata[7:0] == 8'h10))
    else $error("capability id byte wrong");

  a_slot_set_word: assert property ( // R4
    (s_read_head and i_slot_implemented) |=>
      (o_cfg_rdata[31:16] == 16'h0161))
    else $error("protocol word wrong with a slot present");

  // answer handshake and read data path
  a_ack_refuses: assert property (
    o_cfg_ack |=> !o_cfg_ack)
    else $error("request taken during the answer cycle");

  a_ack_needs_take: assert property (
    !req_take |=> !o_cfg_ack)
    else $error("answer without a taken request");

  a_rdata_holds: assert property ( // R17
    !(req_take && i_cfg_rd) |=> $stable(o_cfg_rdata))
    else $error("read data changed without a read");

  // control register lanes and outputs
  a_ctl_untouched: assert property ( // R17
    !ctl_wr_en |=> $stable(ctl_value))
    else $error("control register changed without a control write");

  a_high_lane_kept: assert property ( // R17
    (ctl_wr_en && !i_cfg_be[1]) |=> (ctl_value[14:12] == $past(ctl_value[14:12])))
    else $error("read limit changed with its byte lane closed");

  a_low_lane_kept: assert property ( // R17
    (ctl_wr_en && !i_cfg_be[0]) |=> (ctl_value[7:5] == $past(ctl_value[7:5])))
    else $error("payload limit changed with its byte lane closed");

  a_read_limit_tracks: assert property ( // R16
    (ctl_wr_en && i_cfg_be[1]) |=> (o_read_request_limit == $past(i_cfg_wdata[14:12])))
    else $error("read request limit did not take the written value");

  a_payload_tracks: assert property (
    (ctl_wr_en && i_cfg_be[0]) |=> (o_payload_limit == $past(i_cfg_wdata[7:5])))
    else $error("payload limit did not take the written value");

  a_payload_default: assert property ( // R15
    !st_reg.ctl_written |-> (o_payload_limit == 3'h0))
    else $error("payload limit not at its default before a write");

endmodule // pdc_downstream_caps

// file: tb/pdc_downstream_caps_test.sv
`timescale 1ns/100ps
// self-checking bench for the downstream capability register bank
module pdc_downstream_caps_test
  import pdc_pkg::*;
;
  logic i_clock;
  logic i_rstn;
  logic [7:0] i_cfg_addr;
  logic i_cfg_rd;
  logic i_cfg_wr;
  logic [3:0] i_cfg_be;
  logic [31:0] i_cfg_wdata;
  logic i_slot_implemented;
  logic [31:0] o_cfg_rdata;
  logic o_cfg_ack;
  logic [2:0] o_read_request_limit;
  logic [2:0] o_payload_limit;
  int fails = 0; // mismatches seen
  int n_compared = 0; // comparisons made
  logic [15:0] seed = 16'h001c; // lfsr state, fixed start
  logic [15:0] ctl_model = 16'h2000; // expected control register
  logic [31:0] last_read = 32'h0000_0000; // rdata holds between reads

  pdc_downstream_caps pdc_downstream_caps_inst (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_cfg_addr(i_cfg_addr),
    .i_cfg_rd(i_cfg_rd),
    .i_cfg_wr(i_cfg_wr),
    .i_cfg_be(i_cfg_be),
    .i_cfg_wdata(i_cfg_wdata),
    .i_slot_implemented(i_slot_implemented),
    .o_cfg_rdata(o_cfg_rdata),
    .o_cfg_ack(o_cfg_ack),
    .o_read_request_limit(o_read_request_limit),
    .o_payload_limit(o_payload_limit)
  );

  // 40 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  // next lfsr value; one step per draw keeps runs repeatable
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // what a read of the dword holding byte offset a must return
  function automatic logic [31:0] model_read(input logic [7:0] a, input logic slot,
                                             input logic [15:0] ctl);
    case (a[7:2])
      6'h24: model_read = {2'h0, 5'h00, slot, 4'h6, 4'h1, 8'h00, 8'h10};
      6'h25: model_read = 32'h0000_8001;
      6'h26: model_read = {16'h0000, ctl};
      default: model_read = 32'h0000_0000;
    endcase
  endfunction

  // only the two limit fields take writes, each in its own byte lane
  function automatic logic [15:0] model_write(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [1:0] be);
    logic [15:0] keep;
    keep = {{8{be[1]}}, {8{be[0]}}} & 16'h70e0;
    return (old & ~keep) | (wd & keep);
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one access: request at a falling edge, ack expected one cycle after it is taken
  task automatic do_op(input logic rd, input logic wr, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] exp;
    exp = model_read(a, i_slot_implemented, ctl_model);
    @(negedge i_clock);
    i_cfg_rd = rd;
    i_cfg_wr = wr;
    i_cfg_addr = a;
    i_cfg_be = be;
    i_cfg_wdata = wd;
    @(negedge i_clock);
    check("ack", 32'(1'b1), 32'(o_cfg_ack));
    if (rd) begin
      last_read = exp;
    end
    check("rdata", last_read, o_cfg_rdata);
    if (wr && a[7:2] == 6'h26) begin
      ctl_model = model_write(ctl_model, wd[15:0], be[1:0]);
    end
    i_cfg_rd = 1'b0;
    i_cfg_wr = 1'b0;
    @(negedge i_clock);
    check("ack drop", 32'(1'b0), 32'(o_cfg_ack));
    check("read limit", 32'(ctl_model[14:12]), 32'(o_read_request_limit));
    check("payload limit", 32'(ctl_model[7:5]), 32'(o_payload_limit));
  endtask

  // main sequence
  initial begin
    logic [15:0] r;
    logic [15:0] r2;
    logic [7:0] a;
    i_rstn = 1'b0;
    i_cfg_addr = 8'h00;
    i_cfg_rd = 1'b0;
    i_cfg_wr = 1'b0;
    i_cfg_be = 4'h0;
    i_cfg_wdata = 32'h0000_0000;
    i_slot_implemented = 1'b0;
    repeat (8) @(negedge i_clock);
    check("reset ack", 32'(1'b0), 32'(o_cfg_ack));
    check("reset rdata", 32'h0000_0000, o_cfg_rdata);
    check("reset read limit", 32'h0000_0002, 32'(o_read_request_limit));
    check("reset payload limit", 32'h0000_0000, 32'(o_payload_limit));
    i_rstn = 1'b1;
    do_op(1'b1, 1'b0, 8'h98, 4'h0, 32'h0000_0000);
    do_op(1'b1, 1'b0, 8'h91, 4'h0, 32'h0000_0000);
    do_op(1'b1, 1'b0, 8'h94, 4'h0, 32'h0000_0000);
    i_slot_implemented = 1'b1;
    do_op(1'b1, 1'b0, 8'h92, 4'h0, 32'h0000_0000);
    // writes to fixed words must change nothing, control writes move only the limit fields, and no write disturbs rdata
    // each of the first three writes is followed directly by a read of the same dword
    do_op(1'b0, 1'b1, 8'h90, 4'hf, 32'hffff_ffff);
    do_op(1'b1, 1'b0, 8'h90, 4'h0, 32'h0000_0000);
    do_op(1'b0, 1'b1, 8'h94, 4'hf, 32'hffff_ffff);
    do_op(1'b1, 1'b0, 8'h94, 4'h0, 32'h0000_0000);
    do_op(1'b1, 1'b1, 8'h98, 4'h3, 32'hffff_ffff);
    do_op(1'b1, 1'b0, 8'h98, 4'h0, 32'h0000_0000);
    do_op(1'b0, 1'b1, 8'h98, 4'h2, 32'h0000_0000);
    do_op(1'b0, 1'b1, 8'h98, 4'h1, 32'h0000_0000);
    // mid-run reset must bring the control word back to its default
    @(negedge i_clock);
    i_rstn = 1'b0;
    ctl_model = 16'h2000;
    last_read = 32'h0000_0000;
    @(negedge i_clock);
    check("mid reset rdata", 32'h0000_0000, o_cfg_rdata);
    i_rstn = 1'b1;
    do_op(1'b1, 1'b0, 8'h98, 4'h0, 32'h0000_0000);
    // random traffic over mapped and unmapped dwords
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      r = seed;
      seed = lfsr(seed);
      r2 = seed;
      case (r[1:0])
        2'd0: a = 8'h90;
        2'd1: a = 8'h94;
        2'd2: a = 8'h98;
        default: a = r[15:8];
      endcase
      i_slot_implemented = r[4];
      do_op(r[2] | ~r[3], r[3], a, r[7:4], {r2, r2 ^ r});
    end
    give_verdict();
  end

  // watchdog: the sequence needs well under 4000 cycles
  initial begin
    #(25 * 4000);
    fails++;
    give_verdict();
  end
endmodule // pdc_downstream_caps_test
